// ==== design/lsi_led_status_indicator.v ====
// How it works
// - Green means no alarm, information only
// - Red for alarms, orange for warnings
// - Upgrade start flashes health LED orange
// - Upgrade progress runs diagnostic toward traffic
// - Upgrade success holds health LED orange
// - Upgrade failure flashes LEDs red
// - Network upgrade flashes diagnostic LED orange
// - Test mode refused on base, entered on any other role
// - Long press enters test, all flash green
// - Button response within five seconds
// - Test mode shows live RSSI on LEDs
// - Long press exits test, all flash red
// - Radio path LED green again after exit
// - Test traffic flagged low priority
`timescale 1ns/1ps
`include "lsi_defines.vh"
module lsi_led_status_indicator #(
	parameter HOLD_CYC  = `LSI_HOLD_CYC,
	parameter BLINK_CYC = `LSI_BLINK_CYC
) (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Register port
	input  wire [3:0] regAddr,
	input  wire [7:0] regWdata,
	input  wire       regWr,
	input  wire       regRd,
	output reg  [7:0] regRdata,
	// Status sources
	input  wire       alarmSevere,
	input  wire       alarmWarning,
	input  wire       usbActivity,
	input  wire       serialActivity,
	input  wire       portsOk,
	input  wire       usbHostDetect,
	input  wire       standbyRadio,
	input  wire       cpuOk,
	input  wire       notAssociated,
	input  wire       pathFail,
	input  wire       txActive,
	input  wire       rxActive,
	input  wire [2:0] upgradeStep,
	input  wire [3:0] rssiLevel,
	// Panel button pin, active low
	input  wire       buttonN,
	// LEDs, two bits each {red,green}
	output reg  [1:0] healthLed,
	output reg  [1:0] trafficLed,
	output reg  [1:0] processorLed,
	output reg  [1:0] radioPathLed,
	output reg  [1:0] diagLed,
	// Test mode status
	output wire       testActive,
	output wire       testLowPriority,
	// Interrupt
	output wire       irq
);
	localparam ST_NORMAL = 4'b0001;
	localparam ST_ENTER  = 4'b0010;
	localparam ST_TEST   = 4'b0100;
	localparam ST_EXIT   = 4'b1000;

	wire       buttonLevel;
	reg  [3:0] state_q;
	reg  [3:0] state_d;
	reg  [7:0] ctrl_q;
	reg  [2:0] irqStat_q;
	reg  [2:0] irqMask_q;
	reg  [31:0] holdCnt_q;
	reg  [31:0] blinkCnt_q;
	reg        blink_q;
	reg  [2:0] flashCnt_q;
	reg        pressDone_q;
	reg  [2:0] events;
	wire [1:0] role    = ctrl_q[`LSI_CTRL_ROLE_LSB +: 2];
	wire [1:0] upgrade = ctrl_q[`LSI_CTRL_UPG_LSB +: 2];
	wire       longPress = buttonLevel && (holdCnt_q == HOLD_CYC - 1);
	wire       blinkEdge = (blinkCnt_q == BLINK_CYC - 1);

	lsi_sync uButton (
		.clk      (clk),
		.rst      (rst),
		.pinIn    (~buttonN),
		.levelOut (buttonLevel)
	);

	// Blink timebase
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			blinkCnt_q <= 32'h0;
			blink_q    <= 1'b0;
		end else if (blinkEdge) begin
			blinkCnt_q <= 32'h0;
			blink_q    <= ~blink_q;
		end else begin
			blinkCnt_q <= blinkCnt_q + 32'h1;
		end
	end

	// Long-press timer, one trigger per press
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			holdCnt_q   <= 32'h0;
			pressDone_q <= 1'b0;
		end else if (!buttonLevel) begin
			holdCnt_q   <= 32'h0;
			pressDone_q <= 1'b0;
		end else if (!pressDone_q) begin
			if (longPress) begin
				holdCnt_q   <= 32'h0;
				pressDone_q <= 1'b1;
			end else begin
				holdCnt_q <= holdCnt_q + 32'h1;
			end
		end
	end

	// Test mode sequencer
	always @* begin
		state_d = state_q;
		events  = 3'h0;
		case (state_q)
			ST_NORMAL: begin
				if (longPress && !pressDone_q) begin
					if (role == `LSI_ROLE_BASE) begin
						events[`LSI_IRQ_REFUSED] = 1'b1;
					end else begin
						state_d = ST_ENTER;
						events[`LSI_IRQ_ENTER] = 1'b1;
					end
				end
			end
			ST_ENTER: begin
				if (blinkEdge && flashCnt_q == `LSI_CONFIRM_FLASH - 1) begin
					state_d = ST_TEST;
				end
			end
			ST_TEST: begin
				if (longPress && !pressDone_q) begin
					state_d = ST_EXIT;
					events[`LSI_IRQ_EXIT] = 1'b1;
				end
			end
			ST_EXIT: begin
				if (blinkEdge && flashCnt_q == `LSI_CONFIRM_FLASH - 1) begin
					state_d = ST_NORMAL;
				end
			end
			default: begin
				state_d = ST_NORMAL;
			end
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q    <= ST_NORMAL;
			flashCnt_q <= 3'h0;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) begin
				flashCnt_q <= 3'h0;
			end else if (blinkEdge) begin
				flashCnt_q <= flashCnt_q + 3'h1;
			end
		end
	end

	assign testActive      = (state_q != ST_NORMAL);
	assign testLowPriority = testActive;
	assign irq             = |(irqStat_q & irqMask_q);

	// Registers, set beats write-one-to-clear
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q    <= `LSI_CTRL_RESET;
			irqStat_q <= 3'h0;
			irqMask_q <= 3'h0;
		end else begin
			if (regWr && regAddr == `LSI_REG_CTRL) begin
				ctrl_q <= regWdata;
			end
			if (regWr && regAddr == `LSI_REG_IRQ_MASK) begin
				irqMask_q <= regWdata[2:0];
			end
			if (regWr && regAddr == `LSI_REG_IRQ_STAT) begin
				irqStat_q <= (irqStat_q & ~regWdata[2:0]) | events;
			end else begin
				irqStat_q <= irqStat_q | events;
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				`LSI_REG_CTRL:     regRdata <= ctrl_q;
				`LSI_REG_STATUS:   regRdata <= {4'h0, state_q};
				`LSI_REG_IRQ_STAT: regRdata <= {5'h00, irqStat_q};
				`LSI_REG_IRQ_MASK: regRdata <= {5'h00, irqMask_q};
				`LSI_REG_LEDS:     regRdata <= {trafficLed, processorLed, radioPathLed, diagLed};
				`LSI_REG_RSSI:     regRdata <= {4'h0, rssiLevel};
				default:           regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

	// LED colour selection
	wire [1:0] flashGreen  = blink_q ? `LSI_COL_GREEN  : `LSI_COL_OFF;
	wire [1:0] flashRed    = blink_q ? `LSI_COL_RED    : `LSI_COL_OFF;
	wire [1:0] flashOrange = blink_q ? `LSI_COL_ORANGE : `LSI_COL_OFF;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			healthLed    <= `LSI_COL_OFF;
			trafficLed   <= `LSI_COL_OFF;
			processorLed <= `LSI_COL_OFF;
			radioPathLed <= `LSI_COL_OFF;
			diagLed      <= `LSI_COL_OFF;
		end else if (state_q == ST_ENTER) begin
			healthLed    <= flashGreen;
			trafficLed   <= flashGreen;
			processorLed <= flashGreen;
			radioPathLed <= flashGreen;
			diagLed      <= flashGreen;
		end else if (state_q == ST_EXIT) begin
			healthLed    <= flashRed;
			trafficLed   <= flashRed;
			processorLed <= flashRed;
			radioPathLed <= flashRed;
			diagLed      <= flashRed;
		end else if (state_q == ST_TEST) begin
			// Bar graph of signal strength
			healthLed    <= (rssiLevel > 4'h0) ? `LSI_COL_GREEN : `LSI_COL_OFF;
			trafficLed   <= (rssiLevel > 4'h3) ? `LSI_COL_GREEN : `LSI_COL_OFF;
			processorLed <= (rssiLevel > 4'h6) ? `LSI_COL_GREEN : `LSI_COL_OFF;
			radioPathLed <= (rssiLevel > 4'h9) ? `LSI_COL_GREEN : `LSI_COL_OFF;
			diagLed      <= (rssiLevel > 4'hc) ? `LSI_COL_GREEN : `LSI_COL_OFF;
		end else if (upgrade == `LSI_UPG_FAIL) begin
			healthLed    <= flashRed;
			trafficLed   <= flashRed;
			processorLed <= flashRed;
			radioPathLed <= flashRed;
			diagLed      <= flashRed;
		end else if (upgrade == `LSI_UPG_RUN) begin
			healthLed    <= flashOrange;
			// Running light diagnostic to traffic
			diagLed      <= (upgradeStep[1:0] == 2'h0) ? `LSI_COL_ORANGE : `LSI_COL_OFF;
			radioPathLed <= (upgradeStep[1:0] == 2'h1) ? `LSI_COL_ORANGE : `LSI_COL_OFF;
			processorLed <= (upgradeStep[1:0] == 2'h2) ? `LSI_COL_ORANGE : `LSI_COL_OFF;
			trafficLed   <= (upgradeStep[1:0] == 2'h3) ? `LSI_COL_ORANGE : `LSI_COL_OFF;
		end else begin
			if (upgrade == `LSI_UPG_DONE) begin
				healthLed <= `LSI_COL_ORANGE;
			end else if (alarmSevere) begin
				healthLed <= `LSI_COL_RED;
			end else if (alarmWarning) begin
				healthLed <= `LSI_COL_ORANGE;
			end else begin
				healthLed <= `LSI_COL_GREEN;
			end
			if (usbActivity) begin
				trafficLed <= flashOrange;
			end else if (serialActivity) begin
				trafficLed <= flashGreen;
			end else begin
				trafficLed <= portsOk ? `LSI_COL_GREEN : `LSI_COL_OFF;
			end
			if (usbHostDetect) begin
				processorLed <= flashOrange;
			end else if (standbyRadio) begin
				processorLed <= `LSI_COL_ORANGE;
			end else begin
				processorLed <= cpuOk ? `LSI_COL_GREEN : `LSI_COL_OFF;
			end
			if (notAssociated) begin
				radioPathLed <= flashRed;
			end else if (pathFail) begin
				radioPathLed <= `LSI_COL_RED;
			end else if (txActive) begin
				radioPathLed <= flashOrange;
			end else if (rxActive) begin
				radioPathLed <= flashGreen;
			end else begin
				radioPathLed <= `LSI_COL_GREEN;
			end
			if (ctrl_q[`LSI_CTRL_NETUPG] || ctrl_q[`LSI_CTRL_DIAG]) begin
				diagLed <= flashOrange;
			end else begin
				diagLed <= `LSI_COL_OFF;
			end
		end
	end
endmodule

// ==== design/lsi_defines.vh ====
`ifndef LSI_DEFINES_VH
`define LSI_DEFINES_VH
// Register offsets (word addresses on the plain port)
`define LSI_REG_CTRL      4'h0
`define LSI_REG_STATUS    4'h1
`define LSI_REG_IRQ_STAT  4'h2
`define LSI_REG_IRQ_MASK  4'h3
`define LSI_REG_LEDS      4'h4
`define LSI_REG_RSSI      4'h5
// Control fields
`define LSI_CTRL_ROLE_LSB 0
`define LSI_CTRL_UPG_LSB  2
`define LSI_CTRL_NETUPG   4
`define LSI_CTRL_DIAG     5
`define LSI_CTRL_RESET    8'h00
// Station roles
`define LSI_ROLE_BASE     2'h0
`define LSI_ROLE_REMOTE   2'h1
`define LSI_ROLE_REPEATER 2'h2
// Upgrade states
`define LSI_UPG_IDLE      2'h0
`define LSI_UPG_RUN       2'h1
`define LSI_UPG_DONE      2'h2
`define LSI_UPG_FAIL      2'h3
// Interrupt bits
`define LSI_IRQ_ENTER     0
`define LSI_IRQ_EXIT      1
`define LSI_IRQ_REFUSED   2
// LED colour codes {red,green}
`define LSI_COL_OFF       2'h0
`define LSI_COL_GREEN     2'h1
`define LSI_COL_RED       2'h2
`define LSI_COL_ORANGE    2'h3
// Timing
`define LSI_CLK_MHZ       200
`define LSI_HOLD_MS       4000
`define LSI_HOLD_CYC      (`LSI_HOLD_MS * 1000 * `LSI_CLK_MHZ)
`define LSI_BLINK_MS      250
`define LSI_BLINK_CYC     (`LSI_BLINK_MS * 1000 * `LSI_CLK_MHZ)
`define LSI_CONFIRM_FLASH 4
`endif

// ==== design/lsi_sync.v ====
`timescale 1ns/1ps
// Three-stage pin synchroniser, change taken when stages two and three agree
module lsi_sync (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Pin
	input  wire pinIn,
	// Filtered level
	output reg  levelOut
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q     <= 1'b0;
			s2_q     <= 1'b0;
			s3_q     <= 1'b0;
			levelOut <= 1'b0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				levelOut <= s3_q;
			end
		end
	end
endmodule

// ==== sim/lsi_operator.sv ====
`timescale 1ns/1ps
module lsi_operator (
	// Clock
	input  wire clk,
	// Panel button, active low
	output reg  buttonN
);
	initial buttonN = 1'b1;
	// Press, hold, release to idle high
	task hold(input integer cyc);
		@(posedge clk);
		buttonN <= 1'b0;
		repeat (cyc) @(posedge clk);
		buttonN <= 1'b1;
	endtask
endmodule

// ==== sim/lsi_monitor.sv ====
`timescale 1ns/1ps
module lsi_monitor (
	// Clock, reset, bus
	input wire       clk,
	input wire       rst,
	input wire [3:0] regAddr,
	input wire [7:0] regWdata,
	input wire       regWr,
	// Sources
	input wire       alarmSevere,
	input wire       standbyRadio,
	input wire       usbHostDetect,
	input wire       pathFail,
	input wire       notAssociated,
	input wire       txActive,
	input wire       rxActive,
	// Outputs
	input wire [1:0] healthLed,
	input wire [1:0] trafficLed,
	input wire [1:0] processorLed,
	input wire [1:0] radioPathLed,
	input wire [1:0] diagLed,
	input wire       testActive,
	input wire       testLowPriority
);
	reg  [7:0] ctrl_q;
	wire [4:0] reds = {healthLed[1], trafficLed[1], processorLed[1], radioPathLed[1], diagLed[1]};
	wire [4:0] grns = {healthLed[0], trafficLed[0], processorLed[0], radioPathLed[0], diagLed[0]};
	wire       calm = !testActive && ctrl_q[3:2] == 2'h0;
	wire       link = pathFail && !notAssociated && !txActive && !rxActive;
	always @(posedge clk or posedge rst) begin
		if (rst)
			ctrl_q <= 8'h00;
		else if (regWr && regAddr == 4'h0)
			ctrl_q <= regWdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_enter;
		$rose(testActive);
	endsequence
	sequence s_no_red;
		(reds == 5'h00) [*4];
	endsequence
	a_low_priority: assert property (testLowPriority == testActive)
		else $error("priority flag differs from test mode");
	a_enter_green: assert property (s_enter |=> s_no_red)
		else $error("red shown during enter flash");
	a_exit_red: assert property ($fell(testActive) |-> grns == 5'h00)
		else $error("green shown during exit flash");
	a_severe_red: assert property (calm && alarmSevere |=> healthLed == 2'h2)
		else $error("health not red on alarm");
	a_standby_orange: assert property (calm && standbyRadio && !usbHostDetect |=>
		processorLed == 2'h3)
		else $error("processor not orange on standby");
	a_path_red: assert property (calm && link |=> radioPathLed == 2'h2)
		else $error("radio path not red on failure");
	a_fail_red: assert property (!testActive && ctrl_q[3:2] == 2'h3 |=> grns == 5'h00)
		else $error("green shown on failed upgrade");
	a_net_orange: assert property (calm && ctrl_q[4] |=> diagLed[1] == diagLed[0])
		else $error("diagnostic not orange in network upgrade");
endmodule
bind lsi_led_status_indicator lsi_monitor mon (.clk(clk), .rst(rst), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .alarmSevere(alarmSevere), .standbyRadio(standbyRadio),
	.usbHostDetect(usbHostDetect), .pathFail(pathFail), .notAssociated(notAssociated),
	.txActive(txActive), .rxActive(rxActive), .healthLed(healthLed), .trafficLed(trafficLed),
	.processorLed(processorLed), .radioPathLed(radioPathLed), .diagLed(diagLed),
	.testActive(testActive), .testLowPriority(testLowPriority));

// ==== sim/lsi_led_status_indicator_tb_top.sv ====
`timescale 1ns/1ps
module lsi_led_status_indicator_tb_top;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [3:0]  regAddr = 4'h0;
	reg  [7:0]  regWdata = 8'h00;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg  [11:0] src = 12'h000;
	reg  [2:0]  upgradeStep = 3'h0;
	reg  [3:0]  rssiLevel = 4'h0;
	wire [7:0]  regRdata;
	wire [9:0]  leds;
	wire        buttonN, testActive, irq;
	integer     fail_count = 0;
	integer     checks_done = 0;
	integer     cycles = 0;
	integer     n;
	always #2.5 clk = ~clk;
	lsi_operator op (.clk(clk), .buttonN(buttonN));
	lsi_led_status_indicator #(.HOLD_CYC(20), .BLINK_CYC(4)) dut (.clk(clk), .rst(rst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.alarmSevere(src[11]), .alarmWarning(src[10]), .usbActivity(src[9]),
		.serialActivity(src[8]), .portsOk(src[7]), .usbHostDetect(src[6]), .standbyRadio(src[5]),
		.cpuOk(src[4]), .notAssociated(src[3]), .pathFail(src[2]), .txActive(src[1]),
		.rxActive(src[0]), .upgradeStep(upgradeStep), .rssiLevel(rssiLevel), .buttonN(buttonN),
		.healthLed(leds[9:8]), .trafficLed(leds[7:6]), .processorLed(leds[5:4]),
		.radioPathLed(leds[3:2]), .diagLed(leds[1:0]), .testActive(testActive),
		.testLowPriority(), .irq(irq));
	task check(input [9:0] seen, input [9:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task rc(input [3:0] a, input [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		check({2'h0, regRdata}, {2'h0, e});
	endtask
	task sc(input [11:0] s, input [9:0] m, input [9:0] e);
		@(posedge clk);
		src <= s;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(leds & m, e);
	endtask
	task flash(input [9:0] m, input [9:0] e);
		reg [9:0] acc;
		reg       dark;
		acc = 10'h000;
		dark = 1'b0;
		repeat (8) begin
			@(negedge clk);
			acc = acc | (leds & m);
			if ((leds & m) === 10'h000)
				dark = 1'b1;
		end
		check(acc, e);
		check({9'h0, dark}, 10'h001);
	endtask
	task fc(input [11:0] s, input [9:0] m, input [9:0] e);
		@(posedge clk);
		src <= s;
		repeat (3) @(posedge clk);
		flash(m, e);
	endtask
	task waitTest(input v);
		n = 0;
		while (testActive !== v && n < 60) begin
			@(posedge clk);
			n = n + 1;
		end
		check({9'h0, testActive}, {9'h0, v});
	endtask
	task t_regs;
		rc(4'h0, 8'h00);
		rc(4'h1, 8'h01);
		rc(4'hf, 8'h00);
		rc(4'h2, 8'h00);
	endtask
	task t_sources;
		sc(12'h800, 10'h300, 10'h200);
		sc(12'h400, 10'h300, 10'h300);
		sc(12'h080, 10'h3c0, 10'h140);
		fc(12'h200, 10'h0c0, 10'h0c0);
		fc(12'h100, 10'h0c0, 10'h040);
		sc(12'h020, 10'h030, 10'h030);
		fc(12'h040, 10'h030, 10'h030);
		sc(12'h010, 10'h030, 10'h010);
		sc(12'h004, 10'h00c, 10'h008);
		fc(12'h008, 10'h00c, 10'h008);
		fc(12'h002, 10'h00c, 10'h00c);
		fc(12'h001, 10'h00c, 10'h004);
		sc(12'h000, 10'h3ff, 10'h104);
	endtask
	task t_base;
		wr(4'h3, 8'h07);
		op.hold(40);
		repeat (10) @(posedge clk);
		check({9'h0, testActive}, 10'h000);
		rc(4'h2, 8'h04);
		check({9'h0, irq}, 10'h001);
		wr(4'h2, 8'h04);
		@(negedge clk);
		check({9'h0, irq}, 10'h000);
	endtask
	task t_test;
		wr(4'h0, 8'h01);
		op.hold(30);
		waitTest(1'b1);
		flash(10'h3ff, 10'h155);
		repeat (20) @(posedge clk);
		rc(4'h1, 8'h04);
		@(posedge clk);
		rssiLevel <= 4'hd;
		sc(12'h000, 10'h3ff, 10'h155);
		rc(4'h5, 8'h0d);
		@(posedge clk);
		rssiLevel <= 4'h1;
		sc(12'h000, 10'h3ff, 10'h100);
		op.hold(30);
		flash(10'h3ff, 10'h2aa);
		waitTest(1'b0);
		rc(4'h2, 8'h03);
		sc(12'h000, 10'h00c, 10'h004);
	endtask
	task t_upgrade;
		wr(4'h0, 8'h05);
		fc(12'h000, 10'h300, 10'h300);
		sc(12'h000, 10'h0ff, 10'h003);
		@(posedge clk);
		upgradeStep <= 3'h3;
		sc(12'h000, 10'h0ff, 10'h0c0);
		wr(4'h0, 8'h0d);
		sc(12'h000, 10'h155, 10'h000);
		fc(12'h000, 10'h2aa, 10'h2aa);
		wr(4'h0, 8'h09);
		sc(12'h000, 10'h300, 10'h300);
		wr(4'h0, 8'h10);
		fc(12'h000, 10'h003, 10'h003);
		wr(4'h0, 8'h00);
		sc(12'h000, 10'h003, 10'h000);
	endtask
	task wrap_up;
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			fail_count = fail_count + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_sources;
		t_base;
		t_test;
		t_upgrade;
		wrap_up;
	end
endmodule
